// ---- shared/fwgrp_pkg.sv ----
package fwgrp_pkg;
  // ----------------------------------------------------------------
  // widths and layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned ROW_BYTES       = 128;
  localparam int unsigned ROW_SHIFT       = 7;
  localparam int unsigned WREN_BIT        = 0;
  localparam int unsigned ERASE_EN_BIT    = 1;
  localparam int unsigned BYPASS_BIT      = 6;
  localparam int unsigned WAKE_MAX_CYC    = 3;
  localparam int unsigned SENSE_PULSE_CYC = 1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  STORE_CTL_RST   = 8'h00;
  localparam logic [7:0]  SCALE_RST       = 8'h00;
  localparam logic        VMON_EN_RST     = 1'b1;
  localparam logic        VMON_RST_SEL    = 1'b1;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  // ----------------------------------------------------------------
  // register selects on the core port
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FWGRP_SEL_STORE       = 3'b000,
    FWGRP_SEL_SCALE       = 3'b001,
    FWGRP_SEL_FLASH_WRITE = 3'b010,
    FWGRP_SEL_RESET_SRC   = 3'b011,
    FWGRP_SEL_VMON        = 3'b100
  } fwgrp_sel_t;
endpackage

// ---- shared/fwgrp_if.sv ----
`timescale 1ns/100ps
interface fwgrp_if;
  import fwgrp_pkg::*;
  logic              reg_wr;
  fwgrp_pkg::fwgrp_sel_t reg_sel;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              fl_rd;
  logic              fl_wr;
  logic [ADDR_W-1:0] fl_addr;
  logic [DATA_W-1:0] fl_wdata;
  logic [DATA_W-1:0] fl_rdata;
  logic              fl_busy;
  logic              err_reset;
  logic              idle_req;
  logic              wake;
  logic              run;
  modport dev (
    input  reg_wr, reg_sel, reg_wdata, fl_rd, fl_wr, fl_addr, fl_wdata, idle_req, wake,
    output reg_rdata, fl_rdata, fl_busy, err_reset, run
  );
  modport core (
    output reg_wr, reg_sel, reg_wdata, fl_rd, fl_wr, fl_addr, fl_wdata, idle_req, wake,
    input  reg_rdata, fl_rdata, fl_busy, err_reset, run
  );
endinterface

// ---- rtl/fwgrp_dev.sv ----
// Function
// - modify without supply monitor: refuse, error reset
// - power-on reset enables monitor and reset source
// - interrupts posted during flash operation stay pending
// - one-shot pulse drives sense amp enable
// - one-shot active after reset; bit6 bypasses
// - restore: clear bypass, then nonzero write
// - 128-byte rows; row is address/128
// - wake from idle within three cycles
// - write enable sits at control bit zero
// - software disables interrupts around write enable
// - software re-enables monitor before flash operation
// - reset-source writes direct, power-on flag set
// - software uses internal oscillator during operations
// - error reset sets the flash error flag
// - write needs write enable; erase needs both
`timescale 1ns/100ps
module fwgrp_dev #(
  parameter int unsigned OP_CYC = 4
) (
  input  wire logic                    clock_in,
  input  wire logic                    rstn_in,
  input  wire logic                    por_in,
  fwgrp_if.dev                         bus,
  input  wire logic [7:0]              irq_in,
  output logic      [7:0]              irq_pend_out,
  output logic                         sense_en_out,
  output logic                         row_change_out,
  output logic [fwgrp_pkg::ADDR_W-8:0] row_out,
  output logic [fwgrp_pkg::ADDR_W-1:0] mem_addr_out,
  output logic [7:0]                   mem_wdata_out,
  output logic                         mem_write_out,
  output logic                         mem_erase_out,
  input  wire logic [7:0]              mem_rdata_in
);
  import fwgrp_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the busy counter is eight bits wide
  if (OP_CYC < 1 || OP_CYC > 255) begin : g_bad_op_cyc
    $error("OP_CYC must lie between 1 and 255");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]        program_store_control;
  logic [7:0]        next_program_store_control;
  logic [7:0]        flash_scaling_register;
  logic [7:0]        next_flash_scaling_register;
  logic              vmon_en;
  logic              next_vmon_en;
  logic              vmon_sel;
  logic              next_vmon_sel;
  logic              flash_error_flag;
  logic              next_flash_error_flag;
  logic              power_on_reset_flag;
  logic              next_power_on_reset_flag;
  logic              bypass_arm;
  logic              next_bypass_arm;
  logic              err;
  logic              next_err;
  logic [7:0]        pend;
  logic [7:0]        next_pend;
  logic [7:0]        busy_cnt;
  logic [7:0]        next_busy_cnt;
  logic [ADDR_W-8:0] row;
  logic [ADDR_W-8:0] next_row;
  logic [7:0]        rdata;
  logic [7:0]        next_rdata;
  logic              idle;
  logic              next_idle;
  logic              ok;
  logic              wr_ok;
  logic              er_ok;
  logic              busy;
  logic              modify;

  // ----------------------------------------------------------------
  // guard and register logic
  // ----------------------------------------------------------------
  assign busy   = (busy_cnt != 8'h00);
  assign ok     = vmon_en && vmon_sel;
  assign wr_ok  = program_store_control[WREN_BIT];
  assign er_ok  = wr_ok && program_store_control[ERASE_EN_BIT];
  // a modify attempt is only seen when the write enable is set
  assign modify = bus.fl_wr && !busy && wr_ok;

  always_comb begin
    next_program_store_control  = program_store_control;
    next_flash_scaling_register = flash_scaling_register;
    next_vmon_en                = vmon_en;
    next_vmon_sel               = vmon_sel;
    next_flash_error_flag       = flash_error_flag;
    next_power_on_reset_flag    = power_on_reset_flag;
    next_bypass_arm             = bypass_arm;
    next_err                    = 1'b0;
    if (bus.reg_wr) begin
      case (bus.reg_sel)
        FWGRP_SEL_STORE: begin
          next_program_store_control = {5'h00, bus.reg_wdata[2:0]};
        end
        FWGRP_SEL_SCALE: begin
          next_flash_scaling_register = bus.reg_wdata;
          // clearing bypass only takes effect on the next nonzero write
          if (flash_scaling_register[BYPASS_BIT] && !bus.reg_wdata[BYPASS_BIT]) begin
            next_flash_scaling_register[BYPASS_BIT] = 1'b1;
            next_bypass_arm                         = 1'b1;
          end
        end
        FWGRP_SEL_FLASH_WRITE: begin
          if (bypass_arm && bus.reg_wdata != 8'h00) begin
            next_flash_scaling_register[BYPASS_BIT] = 1'b0;
          end
        end
        FWGRP_SEL_RESET_SRC: begin
          next_vmon_sel            = bus.reg_wdata[1];
          next_power_on_reset_flag = bus.reg_wdata[0];
        end
        FWGRP_SEL_VMON: begin
          next_vmon_en = bus.reg_wdata[7];
        end
        default: begin
        end
      endcase
      // any other register write between clear and kick cancels the restore
      if (bus.reg_sel != FWGRP_SEL_SCALE) next_bypass_arm = 1'b0;
    end
    // a refused modify wins over a same-cycle control write
    if (modify && !ok) begin
      next_err                   = 1'b1;
      next_flash_error_flag      = 1'b1;
      next_program_store_control = STORE_CTL_RST;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      program_store_control  <= STORE_CTL_RST;
      flash_scaling_register <= SCALE_RST;
      vmon_en                <= VMON_EN_RST;
      vmon_sel               <= VMON_RST_SEL;
      power_on_reset_flag    <= 1'b1;
      flash_error_flag       <= 1'b0;
      bypass_arm             <= 1'b0;
      err                    <= 1'b0;
    end else begin
      program_store_control  <= next_program_store_control;
      flash_scaling_register <= next_flash_scaling_register;
      vmon_en                <= next_vmon_en;
      vmon_sel               <= next_vmon_sel;
      power_on_reset_flag    <= next_power_on_reset_flag;
      flash_error_flag       <= next_flash_error_flag;
      bypass_arm             <= next_bypass_arm;
      err                    <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // operation timer and held interrupts
  // ----------------------------------------------------------------
  // pending bits accumulate and are only hidden while an operation runs,
  // so nothing posted during a modify is lost
  always_comb begin
    next_busy_cnt = busy ? busy_cnt - 8'h01 : busy_cnt;
    if (modify && ok) next_busy_cnt = 8'(OP_CYC);
    next_pend = pend | irq_in;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      busy_cnt <= 8'h00;
      pend     <= 8'h00;
    end else begin
      busy_cnt <= next_busy_cnt;
      pend     <= next_pend;
    end
  end

  // memory strobes; refused writes never reach the array
  assign mem_addr_out  = bus.fl_addr;
  assign mem_wdata_out = bus.fl_wdata;
  assign mem_write_out = modify && ok && !program_store_control[ERASE_EN_BIT];
  assign mem_erase_out = modify && ok && er_ok;

  // ----------------------------------------------------------------
  // read path, rows, idle
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = rdata;
    next_row   = row;
    next_idle  = idle;
    if (bus.fl_rd) begin
      next_rdata = mem_rdata_in;
      next_row   = bus.fl_addr[ADDR_W-1:ROW_SHIFT];
    end
    if (bus.idle_req) next_idle = 1'b1;
    if (bus.wake) next_idle = 1'b0;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      row   <= '0;
      rdata <= 8'h00;
      idle  <= 1'b0;
    end else begin
      row   <= next_row;
      rdata <= next_rdata;
      idle  <= next_idle;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // one-shot: high for the first half of an access cycle, full cycle on bypass;
  // bypass touches only this enable, never the read data
  assign sense_en_out   = (bus.fl_rd || bus.fl_wr) &&
                          (flash_scaling_register[BYPASS_BIT] || clock_in);
  assign row_change_out = bus.fl_rd && (bus.fl_addr[ADDR_W-1:ROW_SHIFT] != row);
  assign row_out        = row;
  assign irq_pend_out   = busy ? 8'h00 : pend;
  assign bus.fl_rdata   = rdata;
  assign bus.fl_busy    = busy;
  assign bus.err_reset  = err;
  assign bus.run        = !idle;

  always_comb begin
    case (bus.reg_sel)
      FWGRP_SEL_STORE: begin
        bus.reg_rdata = program_store_control;
      end
      FWGRP_SEL_SCALE: begin
        bus.reg_rdata = flash_scaling_register;
      end
      FWGRP_SEL_RESET_SRC: begin
        bus.reg_rdata = {flash_error_flag, 5'h00, vmon_sel, power_on_reset_flag};
      end
      FWGRP_SEL_VMON: begin
        bus.reg_rdata = {vmon_en, 7'h00};
      end
      default: begin
        bus.reg_rdata = 8'h00;
      end
    endcase
  end
endmodule // fwgrp_dev

// ---- rtl/fwgrp_core.sv ----
`timescale 1ns/100ps
module fwgrp_core (
  input  wire logic                      clock_in,
  input  wire logic                      rstn_in,
  fwgrp_if.core                          bus,
  input  wire logic                      reg_wr_in,
  input  wire fwgrp_pkg::fwgrp_sel_t     reg_sel_in,
  input  wire logic [7:0]                reg_wdata_in,
  output logic      [7:0]                reg_rdata_out,
  input  wire logic                      rd_in,
  input  wire logic                      wr_in,
  input  wire logic [15:0]               addr_in,
  input  wire logic [7:0]                wdata_in,
  output logic      [7:0]                rdata_out,
  output logic                           busy_out,
  output logic                           err_out,
  input  wire logic                      idle_in,
  input  wire logic                      wake_in,
  output logic                           run_out
);
  import fwgrp_pkg::*;
  // software obligations live in firmware; this end only carries cycles
  logic       rd_q;
  logic       next_rd_q;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  always_comb begin
    next_rd_q  = rd_in;
    next_rdata = rdata;
    // device read data stands one cycle after the strobe
    if (rd_q) next_rdata = bus.fl_rdata;
  end
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rd_q  <= 1'b0;
      rdata <= 8'h00;
    end else begin
      rd_q  <= next_rd_q;
      rdata <= next_rdata;
    end
  end
  assign bus.reg_wr    = reg_wr_in;
  assign bus.reg_sel   = reg_sel_in;
  assign bus.reg_wdata = reg_wdata_in;
  assign bus.fl_rd     = rd_in;
  assign bus.fl_wr     = wr_in && !bus.fl_busy;
  assign bus.fl_addr   = addr_in;
  assign bus.fl_wdata  = wdata_in;
  assign bus.idle_req  = idle_in;
  assign bus.wake      = wake_in;
  assign reg_rdata_out = bus.reg_rdata;
  assign rdata_out     = rdata;
  assign busy_out      = bus.fl_busy;
  assign err_out       = bus.err_reset;
  assign run_out       = bus.run;
endmodule // fwgrp_core

// ---- verif/fwgrp_sva.sv ----
`timescale 1ns/100ps
module fwgrp_sva #(
  parameter int unsigned OP_CYC = 4
) (
  input wire logic                  clock_in,
  input wire logic                  rstn_in,
  input wire logic                  reg_wr,
  input wire fwgrp_pkg::fwgrp_sel_t reg_sel,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  fl_wr,
  input wire logic                  fl_busy,
  input wire logic                  err_reset,
  input wire logic                  idle_req,
  input wire logic                  wake,
  input wire logic                  run
);
  import fwgrp_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ------------------------------------------------------------
  // busy length counter, too long for a repetition
  // ------------------------------------------------------------
  logic [7:0] busy_cnt;
  logic [7:0] next_busy_cnt;
  always_comb next_busy_cnt = fl_busy ? busy_cnt + 8'h01 : 8'h00;
  always_ff @(posedge clock_in) busy_cnt <= rstn_in ? next_busy_cnt : 8'h00;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_err_cause: assert property (err_reset |-> $past(fl_wr)) else $error("err without write");
  a_err_pulse: assert property (err_reset |=> !err_reset) else $error("err too long");
  a_err_refuses: assert property (err_reset |-> !fl_busy) else $error("refused op ran");
  a_busy_cause: assert property ($rose(fl_busy) |-> $past(fl_wr)) else $error("busy uncaused");
  a_busy_length: assert property ($fell(fl_busy) |-> busy_cnt == 8'(OP_CYC))
    else $error("busy length wrong");
  a_wren_readback: assert property ($past(reg_wr) && $past(reg_sel) == FWGRP_SEL_STORE
    && reg_sel == FWGRP_SEL_STORE && !err_reset |-> reg_rdata[0] == $past(reg_wdata[0]))
    else $error("write enable readback");
  a_bypass_set: assert property ($past(reg_wr) && $past(reg_sel) == FWGRP_SEL_SCALE
    && $past(reg_wdata[6]) && reg_sel == FWGRP_SEL_SCALE |-> reg_rdata[6])
    else $error("bypass readback");
  a_idle_stops: assert property (idle_req && !wake |=> !run) else $error("idle ignored");
  a_wake_bound: assert property (wake |-> ##[1:3] run) else $error("wake too slow");
  c_error: cover property (err_reset);
  c_modify: cover property ($rose(fl_busy));
  c_wake: cover property (wake ##[1:3] run);
endmodule // fwgrp_sva

// ---- verif/fwgrp_tb.sv ----
`timescale 1ns/100ps
module fwgrp_tb;
  import fwgrp_pkg::*;
  logic       clock_in, rstn_in, por_in, reg_wr_in, rd_in, wr_in, idle_in, wake_in;
  logic       sense_en_out, row_change_out, mem_write_out, mem_erase_out, busy_out, err_out;
  logic       run_out, saw_wr, saw_er, saw_err, sense_v;
  logic [7:0] irq_in, irq_pend_out, mem_wdata_out, mem_rdata_in, reg_wdata_in, reg_rdata_out;
  logic [7:0] wdata_in, rdata_out, cap_d, pend_v;
  logic [15:0] addr_in, mem_addr_out, cap_a;
  logic [8:0] row_out;
  fwgrp_sel_t reg_sel_in;
  int         mismatches, n_tests;
  fwgrp_if bus();
  fwgrp_dev #(.OP_CYC(4)) i_fwgrp_dev(.clock_in, .rstn_in, .por_in, .bus, .irq_in, .irq_pend_out,
    .sense_en_out, .row_change_out, .row_out, .mem_addr_out, .mem_wdata_out, .mem_write_out,
    .mem_erase_out, .mem_rdata_in);
  fwgrp_core i_fwgrp_core(.clock_in, .rstn_in, .bus, .reg_wr_in, .reg_sel_in, .reg_wdata_in,
    .reg_rdata_out, .rd_in, .wr_in, .addr_in, .wdata_in, .rdata_out, .busy_out, .err_out,
    .idle_in, .wake_in, .run_out);
  fwgrp_sva #(.OP_CYC(4)) i_fwgrp_sva(.clock_in, .rstn_in, .reg_wr(bus.reg_wr),
    .reg_sel(bus.reg_sel), .reg_wdata(bus.reg_wdata), .reg_rdata(bus.reg_rdata),
    .fl_wr(bus.fl_wr), .fl_busy(bus.fl_busy), .err_reset(bus.err_reset),
    .idle_req(bus.idle_req), .wake(bus.wake), .run(bus.run));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task wreg(input fwgrp_sel_t s, input logic [7:0] d);
    @(negedge clock_in);
    reg_wr_in = 1'b1; reg_sel_in = s; reg_wdata_in = d;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask
  task rreg(input fwgrp_sel_t s, input logic [7:0] m, input logic [7:0] e, input string nm);
    @(negedge clock_in);
    reg_sel_in = s;
    #2 chk(nm, e, reg_rdata_out & m);
  endtask
  // one flash access; an irq pulse lands while a modify is busy
  task fop(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] irq);
    int k;
    saw_wr = 0; saw_er = 0; saw_err = 0; k = 0;
    @(negedge clock_in);
    wr_in = w; rd_in = !w; addr_in = a; wdata_in = d; mem_rdata_in = d;
    #2 sense_v = sense_en_out;
    @(negedge clock_in);
    wr_in = 0; rd_in = 0;
    @(negedge clock_in);
    irq_in = irq;
    #2 pend_v = irq_pend_out;
    @(negedge clock_in);
    irq_in = 8'h00;
    while (busy_out === 1'b1 && k < 20) begin
      @(negedge clock_in);
      k++;
    end
    if (k == 20) begin
      $display("unexpected busy: expected 0, seen 1");
      mismatches++;
    end
    @(negedge clock_in);
  endtask
  task test_done();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (mem_write_out === 1'b1) begin
      saw_wr = 1; cap_a = mem_addr_out; cap_d = mem_wdata_out;
    end
    if (mem_erase_out === 1'b1) saw_er = 1;
    if (err_out === 1'b1) saw_err = 1;
  end
  // one system clock throughout, so no oscillator switch is modelled
  initial begin
    clock_in = 0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    #50000 mismatches++;
    test_done();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {rstn_in, reg_wr_in, rd_in, wr_in, idle_in, wake_in} = 0; por_in = 1;
    {irq_in, mem_rdata_in, reg_wdata_in, wdata_in, addr_in} = 0; reg_sel_in = FWGRP_SEL_STORE;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in) rstn_in = 1;
    rreg(FWGRP_SEL_RESET_SRC, 8'h83, 8'h03, "reset_src");
    rreg(FWGRP_SEL_VMON, 8'h80, 8'h80, "vmon");
    rreg(FWGRP_SEL_SCALE, 8'h40, 8'h00, "bypass");
    fop(1, 16'h0100, 8'h3C, 8'h00); chk("locked", 0, {saw_wr, saw_er, saw_err});
    wreg(FWGRP_SEL_STORE, 8'h01); rreg(FWGRP_SEL_STORE, 8'h03, 8'h01, "store_ctl");
    fop(1, 16'h0123, 8'h3C, 8'h5A); chk("write", 4, {saw_wr, saw_er, saw_err});
    chk("waddr", 16'h0123, cap_a); chk("wdata", 8'h3C, cap_d);
    chk("irq_busy", 0, pend_v); chk("irq_after", 8'h5A, irq_pend_out);
    wreg(FWGRP_SEL_STORE, 8'h03); fop(1, 16'h0400, 8'h00, 8'h00);
    chk("erase", 2, {saw_wr, saw_er, saw_err}); wreg(FWGRP_SEL_STORE, 8'h00);
    fop(0, 16'h007F, 8'hA5, 8'h00); chk("oneshot", 0, sense_v);
    chk("rdata", 8'hA5, rdata_out); chk("row", 0, row_out);
    fop(0, 16'h0080, 8'h96, 8'h00); chk("row", 1, row_out);
    wreg(FWGRP_SEL_SCALE, 8'h40); rreg(FWGRP_SEL_SCALE, 8'h40, 8'h40, "bypass");
    fop(0, 16'h1234, 8'h69, 8'h00); chk("bypassed", 1, sense_v);
    chk("rdata", 8'h69, rdata_out); chk("row", 9'h024, row_out);
    wreg(FWGRP_SEL_SCALE, 8'h00); wreg(FWGRP_SEL_FLASH_WRITE, 8'h01);
    fop(0, 16'hFFFF, 8'hC3, 8'h00); chk("restored", 0, sense_v); chk("row", 9'h1FF, row_out);
    @(negedge clock_in) idle_in = 1;
    @(negedge clock_in) idle_in = 0;
    @(negedge clock_in) chk("idle", 0, run_out);
    wake_in = 1;
    @(negedge clock_in) wake_in = 0;
    repeat (2) @(negedge clock_in);
    chk("wake", 1, run_out);
    for (int i = 0; i < 2; i++) begin
      wreg(FWGRP_SEL_VMON, i ? 8'h80 : 8'h00); wreg(FWGRP_SEL_RESET_SRC, i ? 8'h01 : 8'h03);
      wreg(FWGRP_SEL_STORE, 8'h01); fop(1, 16'h0200, 8'h11, 8'h00);
      chk("refused", 1, {saw_wr, saw_er, saw_err});
      rreg(FWGRP_SEL_RESET_SRC, 8'h80, 8'h80, "flash_error_flag");
      rreg(FWGRP_SEL_STORE, 8'h01, 8'h00, "store_ctl_clr");
      wreg(FWGRP_SEL_VMON, 8'h80); wreg(FWGRP_SEL_RESET_SRC, 8'h03);
    end
    test_done();
  end
endmodule // fwgrp_tb
